/* File: hdl/trwu_core.sv */
`timescale 1ns/1ps
module trwu_core (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire logic [trwu_pkg::WORD_W-1:0] i_instr,
  input wire logic i_ptr_wr_en,
  input wire logic [trwu_pkg::PTR_W-1:0] i_ptr_wr_data,
  input wire logic i_latch_wr_en,
  input wire logic [trwu_pkg::BYTE_W-1:0] i_latch_wr_data,
  input wire logic [trwu_pkg::WORD_W-1:0] i_pm_rdata,
  output trwu_pkg::trwu_phase_e o_phase,
  output logic o_busy,
  output logic o_accept,
  output trwu_pkg::trwu_pm_req_s o_pm_req,
  output logic [trwu_pkg::PTR_W-1:0] o_table_byte_pointer,
  output logic [trwu_pkg::BYTE_W-1:0] o_table_latch,
  output logic [trwu_pkg::HOLD_N-1:0][trwu_pkg::BYTE_W-1:0] o_hold_regs
);
  import trwu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic trwu_dec_s decode(input logic [WORD_W-1:0] w);
    trwu_dec_s d;
    d.is_read = (w[WORD_W-1:4] == OPC_PREFIX[11:0]) && (w[3:2] == {1'b1, OPC_RD}); // see RULE_01
    d.is_write = (w[WORD_W-1:4] == OPC_PREFIX[11:0]) && (w[3:2] == {1'b1, OPC_WR}); // see RULE_02
    d.mode = trwu_mode_e'(w[1:0]);
    return d;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////
  trwu_phase_e phase;
  trwu_state_e state;
  trwu_dec_s cur;
  logic [PTR_W-1:0] ptr;
  logic [BYTE_W-1:0] latch;
  logic [HOLD_N-1:0][BYTE_W-1:0] hold;
  trwu_pm_req_s pm_req;
  logic busy;
  logic accept;

  trwu_dec_s in_dec;
  trwu_phase_e next_phase;
  trwu_state_e next_state;
  logic take;
  logic dec_end;
  logic exe_q1;
  logic exe_end;
  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;
  logic [PTR_W-1:0] next_ptr;
  logic [BYTE_W-1:0] fetched;
  logic [HOLD_SEL_W-1:0] hold_sel;

  // Decode and sequencing
  assign in_dec = decode(i_instr);
  assign take = (state == ST_IDLE) && (phase == PH_Q1) && i_instr_valid
                && (in_dec.is_read || in_dec.is_write);
  assign dec_end = (state == ST_DECODE) && (phase == PH_Q4);
  assign exe_q1 = (state == ST_EXEC) && (phase == PH_Q1);
  assign exe_end = (state == ST_EXEC) && (phase == PH_Q4);
  assign next_phase = trwu_phase_e'(phase + 2'h1);
  assign next_state = take ? ST_DECODE :
                      dec_end ? ST_EXEC :
                      exe_end ? ST_IDLE : state; // see RULE_07 see RULE_10

  // Modulo 2^21 arithmetic: carries out of the top bit are dropped
  assign ptr_inc = PTR_W'(ptr + PTR_ONE); // see RULE_05 see RULE_12
  assign ptr_dec = PTR_W'(ptr - PTR_ONE); // see RULE_12

  // Pre-increment lands at the end of decode so the exec cycle sees it
  assign next_ptr = (dec_end && cur.mode == MODE_PRE_INC) ? ptr_inc :
                    (exe_end && cur.mode == MODE_POST_INC) ? ptr_inc :
                    (exe_end && cur.mode == MODE_POST_DEC) ? ptr_dec :
                    (busy || !i_ptr_wr_en) ? ptr : i_ptr_wr_data; // see RULE_03 see RULE_09

  // Bit 0 picks the byte lane of the fetched word
  assign fetched = ptr[0] ? i_pm_rdata[WORD_W-1:BYTE_W] : i_pm_rdata[BYTE_W-1:0]; // see RULE_06
  assign hold_sel = ptr[HOLD_SEL_W-1:0]; // see RULE_08

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      phase <= PH_Q1;
      state <= ST_IDLE;
      cur <= '0;
      busy <= 1'b0;
      accept <= 1'b0;
    end else begin
      phase <= next_phase;
      state <= next_state;
      busy <= (next_state != ST_IDLE);
      accept <= take;
      if (take) begin
        cur <= in_dec;
      end
    end
  end

  // Word address is issued so it stands during the exec Q2 phase
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pm_req <= '0;
    end else begin
      pm_req.rd_en <= exe_q1 && cur.is_read; // see RULE_07
      pm_req.word_addr <= ptr[PTR_W-1:1]; // see RULE_04
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ptr <= PTR_RST;
    end else begin
      ptr <= next_ptr;
    end
  end

  // Table op wins over a core write to the latch in the same Q4
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      latch <= BYTE_RST;
    end else if (exe_end && cur.is_read) begin
      latch <= fetched; // see RULE_04 see RULE_07
    end else if (i_latch_wr_en && !busy) begin
      latch <= i_latch_wr_data;
    end
  end

  // Holding registers only stage data; there is no array write port here
  for (genvar g = 0; g < HOLD_N; g++) begin : g_hold
    always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
        hold[g] <= BYTE_RST;
      end else if (exe_end && cur.is_write && (hold_sel == HOLD_SEL_W'(g))) begin
        hold[g] <= latch; // see RULE_08 see RULE_10 see RULE_11
      end
    end
  end

  assign o_phase = phase;
  assign o_busy = busy;
  assign o_accept = accept;
  assign o_pm_req = pm_req;
  assign o_table_byte_pointer = ptr;
  assign o_table_latch = latch;
  assign o_hold_regs = hold;
endmodule : trwu_core

/* File: hdl/trwu_pkg.sv */
// Overview of operation
// RULE_01 - Word 0x0008-0x000B decodes as table read
// RULE_02 - Word 0x000C-0x000F decodes as table write
// RULE_03 - Read modes: hold, post-inc, post-dec, pre-inc
// RULE_04 - Read loads addressed byte into table latch
// RULE_05 - Byte pointer is 21 bits wide
// RULE_06 - Pointer bit 0 picks low/high byte
// RULE_07 - Read: decode cycle, Q2 fetch, Q4 latch
// RULE_08 - Write copies latch to holding register[ptr[2:0]]
// RULE_09 - Write modes: hold, post-inc, post-dec, pre-inc
// RULE_10 - Write: decode cycle, Q2 latch read, Q4 store
// RULE_11 - Table write never touches the memory array
// RULE_12 - Pointer wraps; no status flag changes
package trwu_pkg;
  localparam int PTR_W = 21;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int HOLD_N = 8;
  localparam int HOLD_SEL_W = 3;
  localparam int WADDR_W = PTR_W - 1;
  localparam logic [13:0] OPC_PREFIX = 14'h0000;
  localparam logic OPC_RD = 1'h0;
  localparam logic OPC_WR = 1'h1;
  localparam logic [PTR_W-1:0] PTR_ONE = 21'h000001;
  localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    MODE_HOLD = 2'b00,
    MODE_POST_INC = 2'b01,
    MODE_POST_DEC = 2'b10,
    MODE_PRE_INC = 2'b11
  } trwu_mode_e;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } trwu_phase_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DECODE = 2'b01,
    ST_EXEC = 2'b10
  } trwu_state_e;

  typedef struct packed {
    logic is_read;
    logic is_write;
    trwu_mode_e mode;
  } trwu_dec_s;

  typedef struct packed {
    logic rd_en;
    logic [WADDR_W-1:0] word_addr;
  } trwu_pm_req_s;
endpackage : trwu_pkg

/* File: testbench/trwu_core_asserts.sv */
`timescale 1ns/1ps
module trwu_core_asserts (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input trwu_pkg::trwu_phase_e o_phase,
  input wire logic o_busy,
  input wire logic o_accept,
  input trwu_pkg::trwu_pm_req_s o_pm_req,
  input wire logic [20:0] o_table_byte_pointer
);
  import trwu_pkg::*;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire tk = o_phase == PH_Q1 && !o_busy && i_instr_valid && i_instr[15:3] == 13'h0001;
  wire rd = o_pm_req.rd_en;
  a_take_accept: assert property (tk |=> o_accept) else $error("no accept");
  a_accept_pulse: assert property (o_accept |=> !o_accept) else $error("long accept");
  a_busy_span: assert property (tk |=> o_busy [*7]) else $error("busy short");
  a_fetch_q2: assert property (rd |-> o_phase == PH_Q2) else $error("fetch phase");
  a_fetch_one: assert property (rd |=> !rd) else $error("fetch long");
  a_read_fetch: assert property (tk && !i_instr[2] |-> ##[5:6] rd) else $error("no fetch");
  a_write_quiet: assert property (tk && i_instr[2] |=> !rd [*8]) else $error("write read");
  a_fetch_addr: assert property (rd |-> o_pm_req.word_addr == o_table_byte_pointer[20:1])
    else $error("bad addr");
  a_pre_inc: assert property (tk && i_instr[1:0] == 2'h3 |-> ##5
    o_table_byte_pointer == $past(o_table_byte_pointer, 5) + PTR_ONE) else $error("pre inc");
  c_read: cover property (tk && !i_instr[2]);
  c_write: cover property (tk && i_instr[2]);
  c_fetch: cover property (rd);
endmodule : trwu_core_asserts
bind trwu_core trwu_core_asserts chk_u (.*);

/* File: testbench/trwu_pmem_model.sv */
`timescale 1ns/1ps
module trwu_pmem_model (
  input wire logic i_clk_sys,
  input trwu_pkg::trwu_pm_req_s i_pm_req,
  output logic [15:0] o_rdata
);
  logic [1:0] age;
  initial age = 2'h0;
  initial o_rdata = 16'hFFFF;
  // Word holds for four cycles after a fetch, then toggles so stale data cannot pass
  always @(posedge i_clk_sys) begin
    if (i_pm_req.rd_en) begin
      o_rdata <= {i_pm_req.word_addr[7:0] ^ 8'h5A, i_pm_req.word_addr[7:0] ^ 8'hC3};
      age <= 2'h3;
    end else if (age != 2'h0) begin
      age <= age - 2'h1;
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule : trwu_pmem_model

/* File: testbench/trwu_core_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t %h %h", $time, (a), (b)); end end
module trwu_core_tb;
  import trwu_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic vld = 1'b0;
  logic pwe = 1'b0;
  logic [15:0] ins = 16'h0000;
  logic [15:0] pmd;
  logic [20:0] pwd = 21'h0;
  logic [7:0] lwd = 8'h00;
  logic [20:0] ptr;
  logic [20:0] e;
  logic [7:0] lat;
  logic [7:0][7:0] hold;
  trwu_phase_e ph;
  logic busy;
  trwu_pm_req_s req;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [20:0] rows [8][3] = '{'{21'h8, 21'hA356, 21'hA356}, '{21'h9, 21'h1FFFFF, 21'h0},
    '{21'hA, 21'h0, 21'h1FFFFF}, '{21'hB, 21'h1A357, 21'h1A358},
    '{21'hC, 21'hA356, 21'hA356}, '{21'hD, 21'hA357, 21'hA358},
    '{21'hE, 21'hA35A, 21'hA359}, '{21'hF, 21'h1389A, 21'h1389B}};
  trwu_core dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_instr_valid(vld), .i_instr(ins),
    .i_ptr_wr_en(pwe), .i_ptr_wr_data(pwd), .i_latch_wr_en(pwe), .i_latch_wr_data(lwd),
    .i_pm_rdata(pmd), .o_phase(ph), .o_busy(busy), .o_accept(), .o_pm_req(req),
    .o_table_byte_pointer(ptr), .o_table_latch(lat), .o_hold_regs(hold));
  trwu_pmem_model mem_u (.i_clk_sys(i_clk_sys), .i_pm_req(req), .o_rdata(pmd));
  initial begin
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_sim();
    end
  end
  task end_sim;
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task load(input logic [20:0] p, input logic [7:0] l);
    pwd = p;
    lwd = l;
    pwe = 1'b1;
    @(posedge i_clk_sys) #1 pwe = 1'b0;
  endtask : load
  task run(input logic [15:0] w);
    while (!(ph == PH_Q1 && !busy)) @(posedge i_clk_sys) #1;
    vld = 1'b1;
    ins = w;
    @(posedge i_clk_sys) #1 vld = 1'b0;
    repeat (10) @(posedge i_clk_sys) #1;
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_clk_sys);
    #1 i_rst = 1'b0;
    `CHK(ptr, 21'h0)
    for (int i = 0; i < 8; i++) begin
      load(rows[i][1], 8'h50 + 8'(i));
      run(rows[i][0][15:0]);
      e = rows[i][0][1:0] == 2'h3 ? rows[i][1] + 21'h1 : rows[i][1];
      `CHK(ptr, rows[i][2])
      if (i < 4) `CHK(lat, e[0] ? e[8:1] ^ 8'h5A : e[8:1] ^ 8'hC3)
      else `CHK(hold[e[2:0]], 8'h50 + 8'(i))
    end
    load(21'hABC, 8'hA5);
    vld = 1'b1;
    ins = 16'h0010;
    repeat (8) @(posedge i_clk_sys) #1;
    `CHK(busy, 1'b0)
    `CHK(ptr, 21'hABC)
    ins = 16'h000F;
    repeat (6) @(posedge i_clk_sys) #1;
    i_rst = 1'b1;
    vld = 1'b0;
    @(posedge i_clk_sys) #1 i_rst = 1'b0;
    `CHK(hold, 64'h0)
    `CHK(ptr, 21'h0)
    `CHK(lat, 8'h00)
    `CHK(busy, 1'b0)
    `CHK(ph, PH_Q1)
    end_sim();
  end
endmodule : trwu_core_tb
